// File: rtl/acps_adc_dev.sv
/*
 * Converter end: calibration pulse sequencer, lower-bit takeover and
 * three-cycle output pipeline.
 * Power-up pulses come from the prescaler until the mask counter carries;
 * after that the select pin picks the internal periodic counter or
 * falling edges on the external pulse pin.
 * A pulse that finds no step running starts one eleven-cycle step; the low output bits freeze for
 * four of those cycles while the takeover output marks the hold.
 * Assumes control pins may change at any time; they pass two flops.
 * Assumes the sample word is settled at every rising edge.
 */
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module acps_adc_dev #(
    parameter int PWR_W = acps_pkg::PWR_W,   // Power-up mask counter width
    parameter int PER_W = acps_pkg::PER_W    // Periodic pulse counter width
) (
    input  wire logic                       mclk_in,            // Sample clock
    input  wire logic                       rst_b_in,           // Async reset, active low
    acps_link_if.dev                        link,               // Pins to the controller
    input  wire logic [acps_pkg::DATA_W-1:0] sample_in,          // Quantised analog sample
    output logic                            pwrup_done_out,     // Power-up calibration done
    output logic                            cal_busy_out,       // Calibration step running
    output logic                            takeover_out,       // Low bits held
    output logic                            cal_cycle_done_out  // Seventh pulse finished
);
    import acps_pkg::*;

    typedef struct packed {
        // Sequencer state and pin synchronisers
        acps_dev_st_t         st;
        logic [1:0]           sel_sy;
        logic [1:0]           cal_sy;
        logic [1:0]           ceb_sy;
        logic [1:0]           run_sy;
        logic                 cal_prev;
        // Prescaler and pulse counters
        logic [PRESC_W-1:0]   presc;
        logic [PWR_W-1:0]     pwr;
        logic [PER_W-1:0]     per;
        // Step engine
        logic [STEP_W-1:0]    step;
        logic [NPULSE_W-1:0]  npulse;
        logic                 cyc_done;
        // Output pipeline
        logic [DATA_W-1:0]    p0;
        logic [DATA_W-1:0]    p1;
        logic [DATA_W-1:0]    p2;
        logic [DATA_W-1:0]    dout;
    } acps_dev_state_t;

    // Calibration pin syncs reset high, its idle level, so a
    // release of reset never shows a false falling edge
    localparam acps_dev_state_t RESET_STATE = '{
        st:       DEV_OFF,
        sel_sy:   '0,
        cal_sy:   '1,
        ceb_sy:   '1,
        run_sy:   '0,
        cal_prev: 1'b1,
        presc:    '0,
        pwr:      '0,
        per:      '0,
        step:     '0,
        npulse:   '0,
        cyc_done: 1'b0,
        p0:       '0,
        p1:       '0,
        p2:       '0,
        dout:     '0
    };

    acps_dev_state_t q;
    acps_dev_state_t n;
    logic            en;
    logic            tick;
    logic            fall;
    logic            pulse;
    logic            take;

    // Next-state logic for the whole end
    always_comb begin
        n = q;
        // Pins pass two flops; only the second stage is read below
        n.sel_sy = {q.sel_sy[0], link.sel};
        n.cal_sy = {q.cal_sy[0], link.cal_trig};
        n.ceb_sy = {q.ceb_sy[0], link.ce_b};
        n.run_sy = {q.run_sy[0], link.run};
        n.cal_prev = q.cal_sy[1];

        // Enable, prescaler tick and detected falling edge
        en   = q.run_sy[1] & ~q.ceb_sy[1];
        tick = (q.presc == '1);
        fall = q.cal_prev & ~q.cal_sy[1];

        // Defaults: no pulse, prescaler runs on every clock
        pulse = 1'b0;
        n.cyc_done = 1'b0;
        n.presc = q.presc + 1'b1;

        unique case (q.st)
            DEV_OFF: begin
                // Only left while enabled; the disable block holds it here
                n.st = DEV_PWRUP;
            end
            DEV_PWRUP: begin
                // Every tick before the carry starts one step
                // Carry masks the last tick and every later one
                if (tick) begin
                    n.pwr = q.pwr + 1'b1;
                    pulse = (q.pwr != '1);
                    if (q.pwr == '1) begin
                        n.st = DEV_RUN;
                    end
                end
            end
            DEV_RUN: begin
                if (q.sel_sy[1]) begin
                    // Free running; analog input plays no part
                    if (tick) begin
                        n.per = q.per + 1'b1;
                        pulse = (q.per == '1);
                    end
                end else begin
                    // A tied input never gives an edge: no periodic pulses
                    pulse = fall;
                end
            end
            default: begin
                n.st = DEV_OFF;
            end
        endcase

        // Step engine; a pulse during a running step is dropped
        // Step 1 is the edge after detection, step 11 the last busy cycle;
        // seven finished steps of any source make one calibration cycle
        if (q.step != '0) begin
            if (q.step == STEP_LAST) begin
                n.step = '0;
                n.npulse = (q.npulse == PULSE_LAST) ? '0 : q.npulse + 1'b1;
                n.cyc_done = (q.npulse == PULSE_LAST);
            end else begin
                n.step = q.step + 1'b1;
            end
        end else if (pulse) begin
            n.step = STEP_FIRST;
        end

        // Disable restarts power-up from a clean count
        // Pin syncs keep running so the next edge is still seen
        if (!en) begin
            n.st     = DEV_OFF;
            n.presc  = '0;
            n.pwr    = '0;
            n.per    = '0;
            n.step   = '0;
            n.npulse = '0;
        end

        // Freeze chosen from the next step value, so the held low bits
        // stand in exactly the cycles that report takeover
        take = (n.step >= TAKE_FIRST) && (n.step <= TAKE_LAST);

        // Pipeline: sampled at edge E, on the pins after edge E+3
        // Upper bits never stall; low bits hold while take is set
        n.p0 = sample_in;
        n.p1 = q.p0;
        n.p2 = q.p1;
        n.dout[DATA_W-1:LSB_W] = q.p2[DATA_W-1:LSB_W];
        n.dout[LSB_W-1:0] = take ? q.dout[LSB_W-1:0] : q.p2[LSB_W-1:0];
    end

    // State register; reset loads constants only
    // Whole state in one register, so one reset covers every counter
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q <= RESET_STATE;
        end else begin
            q <= n;
        end
    end

    // Outputs straight from flops
    assign link.dout          = q.dout;

    // Status decodes of registered state, no added latency
    assign pwrup_done_out     = (q.st == DEV_RUN);
    assign cal_busy_out       = (q.step != '0);
    assign takeover_out       = (q.step >= TAKE_FIRST) && (q.step <= TAKE_LAST);
    assign cal_cycle_done_out = q.cyc_done;
endmodule

// File: rtl/acps_pkg.sv
/*
 * Shared constants and types for the calibration pulse sequencer:
 * word widths, counter widths, sequence timing, controller register map.
 * Assumes both ends run on the same 25 MHz sample clock.
 */
package acps_pkg;

    // Converter word and pipeline
    localparam int DATA_W   = 10;
    localparam int LSB_W    = 5;
    localparam int PRESC_W  = 4;     // Divide by sixteen
    localparam int PWR_W    = 14;    // Power-up mask counter
    localparam int PER_W    = 24;    // Periodic pulse counter
    localparam int STEP_W   = 4;
    localparam int NPULSE_W = 3;

    // One calibration step, counted from the detecting edge
    localparam logic [STEP_W-1:0]   STEP_FIRST = 4'h1;
    localparam logic [STEP_W-1:0]   TAKE_FIRST = 4'h7;
    localparam logic [STEP_W-1:0]   TAKE_LAST  = 4'ha;
    localparam logic [STEP_W-1:0]   STEP_LAST  = 4'hb;
    localparam logic [NPULSE_W-1:0] PULSE_LAST = 3'h6;   // Seven pulses per calibration

    // Timing at 25 MHz
    localparam int CLK_NS     = 40;
    localparam int CAL_LOW_NS = 80;  // Low time incl. two-flop sampling
    localparam int CAL_LOW_CYC = (CAL_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESTART_NS = 160;
    localparam int RESTART_CYC = (RESTART_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W      = 8;

    // Controller register map, Avalon-MM byte addresses
    localparam int AV_ADDR_W = 4;
    localparam int AV_DATA_W = 32;
    localparam logic [AV_ADDR_W-1:0] REG_CTRL   = 4'h0;
    localparam logic [AV_ADDR_W-1:0] REG_CMD    = 4'h4;
    localparam logic [AV_ADDR_W-1:0] REG_STATUS = 4'h8;
    localparam logic [AV_ADDR_W-1:0] REG_DATA   = 4'hc;
    localparam int CTRL_SEL_BIT   = 0;
    localparam int CTRL_RUN_BIT   = 1;
    localparam int CTRL_CEB_BIT   = 2;
    localparam int CMD_CAL_BIT    = 0;
    localparam int CMD_RST_BIT    = 1;
    localparam int STAT_BUSY_BIT  = 0;
    localparam logic CTRL_SEL_RST = 1'h0;
    localparam logic CTRL_RUN_RST = 1'h1;
    localparam logic CTRL_CEB_RST = 1'h0;

    typedef enum logic [2:0] {
        DEV_OFF   = 3'b001,
        DEV_PWRUP = 3'b010,
        DEV_RUN   = 3'b100
    } acps_dev_st_t;

    typedef enum logic [2:0] {
        CTL_RESTART = 3'b001,
        CTL_IDLE    = 3'b010,
        CTL_CALLOW  = 3'b100
    } acps_ctl_st_t;

endpackage

// File: rtl/acps_link_if.sv
/*
 * Pin-level link between converter and board controller.
 * Assumes both ends and the bench share one sample clock.
 */
`timescale 1ns/1ps
interface acps_link_if;
    import acps_pkg::*;

    logic              sel;       // 1 internal, 0 external periodic pulses
    logic              cal_trig;  // External calibration pulse, falling edge
    logic              ce_b;      // Chip enable, active low
    logic              run;       // Reset pin, 1 lets the converter run
    logic [DATA_W-1:0] dout;      // Converted word

    modport dev (input sel, input cal_trig, input ce_b, input run, output dout);
    modport ctl (output sel, output cal_trig, output ce_b, output run, input dout);
endinterface

// File: rtl/acps_board_ctl.sv
/*
 * Board controller end: Avalon-MM slave with control, command, status
 * and data registers, driving select, calibration pulse, enable, reset.
 * Assumes a well-behaved Avalon master on the same clock.
 */
`timescale 1ns/1ps
module acps_board_ctl #(
    parameter int CAL_LOW_CYC = acps_pkg::CAL_LOW_CYC,  // Pulse low time, clocks
    parameter int RESTART_CYC = acps_pkg::RESTART_CYC   // Enable high time, clocks
) (
    input  wire logic                           mclk_in,           // Sample clock
    input  wire logic                           rst_b_in,          // Async reset, active low
    input  wire logic [acps_pkg::AV_ADDR_W-1:0] avs_address,       // Byte address
    input  wire logic                           avs_read,          // Read request
    input  wire logic                           avs_write,         // Write request
    input  wire logic [acps_pkg::AV_DATA_W-1:0] avs_writedata,     // Write data
    output logic      [acps_pkg::AV_DATA_W-1:0] avs_readdata,      // Read data
    output logic                                avs_waitrequest,   // Stall
    acps_link_if.ctl                            link               // Pins to the converter
);
    import acps_pkg::*;

    typedef struct packed {
        acps_ctl_st_t         st;
        logic [CNT_W-1:0]     cnt;
        logic                 sel;
        logic                 run;
        logic                 ceb;
        logic                 ack;
        logic [AV_DATA_W-1:0] rdata;
        logic [DATA_W-1:0]    d_sy0;
        logic [DATA_W-1:0]    d_sy1;
    } acps_ctl_state_t;

    localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CAL_LOW_CYC - 1);
    localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(RESTART_CYC - 1);

    localparam acps_ctl_state_t RESET_STATE = '{
        st: CTL_RESTART, cnt: '0, sel: CTRL_SEL_RST, run: CTRL_RUN_RST,
        ceb: CTRL_CEB_RST, ack: 1'b0, rdata: '0, d_sy0: '0, d_sy1: '0
    };

    acps_ctl_state_t q;
    acps_ctl_state_t n;
    logic            req;
    logic            wr_take;

    // Next-state logic
    always_comb begin
        n = q;
        n.d_sy0 = link.dout;
        n.d_sy1 = q.d_sy0;
        req = avs_read | avs_write;
        // One wait state: the bus edge after the first takes the access
        n.ack = req & ~q.ack;
        wr_take = avs_write & q.ack;

        // Read data is captured in the first cycle and stands while ack
        n.rdata = '0;
        unique case (avs_address)
            REG_CTRL: begin
                n.rdata[CTRL_SEL_BIT] = q.sel;
                n.rdata[CTRL_RUN_BIT] = q.run;
                n.rdata[CTRL_CEB_BIT] = q.ceb;
            end
            REG_STATUS: begin
                n.rdata[STAT_BUSY_BIT] = (q.st != CTL_IDLE);
            end
            REG_DATA: begin
                n.rdata[DATA_W-1:0] = q.d_sy1;
            end
            default: begin
                n.rdata = '0;
            end
        endcase

        if (wr_take && avs_address == REG_CTRL) begin
            n.sel = avs_writedata[CTRL_SEL_BIT];
            n.run = avs_writedata[CTRL_RUN_BIT];
            n.ceb = avs_writedata[CTRL_CEB_BIT];
        end

        unique case (q.st)
            CTL_RESTART: begin
                // Enable held high long enough to be seen through two flops
                n.cnt = q.cnt + 1'b1;
                if (q.cnt == RST_LAST) begin
                    n.st  = CTL_IDLE;
                    n.cnt = '0;
                end
            end
            CTL_IDLE: begin
                // Commands while busy are ignored; software polls busy first
                if (wr_take && avs_address == REG_CMD) begin
                    if (avs_writedata[CMD_RST_BIT]) begin
                        n.st = CTL_RESTART;
                    end else if (avs_writedata[CMD_CAL_BIT]) begin
                        n.st = CTL_CALLOW;
                    end
                end
            end
            CTL_CALLOW: begin
                n.cnt = q.cnt + 1'b1;
                if (q.cnt == CAL_LAST) begin
                    n.st  = CTL_IDLE;
                    n.cnt = '0;
                end
            end
            default: begin
                n.st  = CTL_IDLE;
                n.cnt = '0;
            end
        endcase
    end

    // State register; reset starts with a power-up restart
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q <= RESET_STATE;
        end else begin
            q <= n;
        end
    end

    // Pin and bus outputs
    assign link.sel         = q.sel;
    assign link.run         = q.run;
    assign link.ce_b        = q.ceb | (q.st == CTL_RESTART);
    assign link.cal_trig    = (q.st != CTL_CALLOW);
    assign avs_readdata     = q.rdata;
    assign avs_waitrequest  = (avs_read | avs_write) & ~q.ack;
endmodule

// File: testbench/acps_link_sva.sv
/*
 * Checker for the pins between converter and controller, and the
 * converter's calibration status outputs.
 * Assumes it is instantiated beside the link interface, one clock.
 */
`timescale 1ns/1ps
module acps_link_sva
    import acps_pkg::*;
(
    input wire logic              mclk_in,        // Sample clock
    input wire logic              rst_b_in,       // Reset, active low
    input wire logic              sel,            // Source select
    input wire logic              cal_trig,       // External pulse pin
    input wire logic              ce_b,           // Enable, active low
    input wire logic              run,            // Run pin
    input wire logic [DATA_W-1:0] dout,           // Output word
    input wire logic              pwrup_done_out, // Power-up finished
    input wire logic              cal_busy_out,   // Step running
    input wire logic              takeover_out    // Low bits held
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    // One step: six free cycles, four held, then released
    sequence s_lead;
        !takeover_out [*6];
    endsequence
    sequence s_hold;
        takeover_out [*4] ##1 !takeover_out;
    endsequence

    property p_trig_low;
        $fell(cal_trig) |-> ##1 !cal_trig;
    endproperty
    a_trig_low: assert property (p_trig_low) else $error("pulse pin low for a single cycle");
    // Pin passes two sync flops before detection
    property p_ext_start;
        $fell(cal_trig) && !sel && pwrup_done_out && !cal_busy_out |-> ##[2:5] $rose(cal_busy_out);
    endproperty
    a_ext_start: assert property (p_ext_start) else $error("falling pulse started no step");
    property p_busy_len;
        $rose(cal_busy_out) |-> cal_busy_out [*8] ##1 cal_busy_out [*3] ##1 !cal_busy_out;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("step not eleven cycles");
    property p_take_start;
        $rose(cal_busy_out) |-> s_lead ##1 s_hold;
    endproperty
    a_take_start: assert property (p_take_start) else $error("takeover window misplaced");
    property p_take_busy;
        takeover_out |-> cal_busy_out;
    endproperty
    a_take_busy: assert property (p_take_busy) else $error("takeover outside a step");
    property p_lsb_hold;
        takeover_out |-> $stable(dout[LSB_W-1:0]);
    endproperty
    a_lsb_hold: assert property (p_lsb_hold) else $error("low bits moved during takeover");
    property p_restart_len;
        $rose(ce_b) |-> ce_b [*4];
    endproperty
    a_restart_len: assert property (p_restart_len) else $error("restart enable pulse too short");
    property p_restart_clear;
        $rose(ce_b) |-> ##[1:5] !pwrup_done_out;
    endproperty
    a_restart_clear: assert property (p_restart_clear) else $error("restart left power-up done");
    property p_run_gate;
        $fell(run) |-> ##[1:5] !pwrup_done_out;
    endproperty
    a_run_gate: assert property (p_run_gate) else $error("power-up done kept with run low");
endmodule

// File: testbench/test_adc_calibration_pulse_sequencer.sv
/*
 * Self-checking bench: both ends joined by the link, software side
 * driven over Avalon-MM, output word compared with a pipeline model.
 * Assumes shortened counter widths on the converter end.
 */
`timescale 1ns/1ps
module test_adc_calibration_pulse_sequencer;
    import acps_pkg::*;
    localparam int PW      = 2;                // Short power-up count
    localparam int PR      = 2;                // Short periodic count
    localparam int PWR_CYC = 2 ** (PW + 4);
    localparam int PER_CYC = 2 ** (PR + 4);
    logic                 mclk_in, rst_b_in, avs_read, avs_write, avs_waitrequest, busy_p;
    logic [DATA_W-1:0]    sample_in, expw;
    logic [AV_ADDR_W-1:0] avs_address;
    logic [31:0]          avs_writedata, avs_readdata, rd;
    logic                 pwrup_done_out, cal_busy_out, takeover_out, cal_cycle_done_out;
    logic [LSB_W-1:0]     hold_lsb;
    logic [DATA_W-1:0]    q[$];
    int                   num_errors, n_compared, cyc, rises, since_done, rise_at, ivl, r0, t0;
    bit                   seen_done;

    acps_link_if link_bus();
    acps_adc_dev #(.PWR_W(PW), .PER_W(PR)) i_acps_adc_dev (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .link(link_bus), .sample_in(sample_in), .pwrup_done_out(pwrup_done_out),
        .cal_busy_out(cal_busy_out), .takeover_out(takeover_out), .cal_cycle_done_out(cal_cycle_done_out));
    acps_board_ctl i_acps_board_ctl (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link_bus));
    acps_link_sva i_acps_link_sva (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .sel(link_bus.sel),
        .cal_trig(link_bus.cal_trig), .ce_b(link_bus.ce_b), .run(link_bus.run), .dout(link_bus.dout),
        .pwrup_done_out(pwrup_done_out), .cal_busy_out(cal_busy_out), .takeover_out(takeover_out));

    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %0h, seen %0h", name, e, g);
        end
    endtask

    // One bus cycle, held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [AV_ADDR_W-1:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge mclk_in);
        avs_address   <= a;
        avs_writedata <= wd;
        avs_write     <= wr;
        avs_read      <= !wr;
        @(posedge mclk_in);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            @(posedge mclk_in);
        end
        chk("wait states", 32'h1, n);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Done must drop first, then return after the divided count
    task automatic pwrup_time;
        t0 = cyc;
        while (pwrup_done_out !== 1'b0 && cyc - t0 < 10) @(posedge mclk_in);
        chk("power-up cleared", 32'h0, {31'h0, pwrup_done_out});
        while (pwrup_done_out !== 1'b1 && cyc - t0 < 300) @(posedge mclk_in);
        chk("power-up span ok", 32'h1, {31'h0, (cyc - t0 >= PWR_CYC && cyc - t0 <= PWR_CYC + 12)});
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Fresh random sample every edge; seeded in the thread that draws
    initial begin
        void'($urandom(5487));
        sample_in = '0;
        forever begin
            @(posedge mclk_in);
            sample_in <= DATA_W'($urandom);
        end
    end

    // Pipeline model: word three edges late, low bits held in takeover
    always @(negedge mclk_in) begin
        if (rst_b_in !== 1'b1) begin
            q.delete();
        end else begin
            q.push_back(sample_in);
            if (q.size() > 4) begin
                expw = q.pop_front();
                if (takeover_out === 1'b1) expw[LSB_W-1:0] = hold_lsb;
                hold_lsb = expw[LSB_W-1:0];
                chk("output word", {22'h0, expw}, {22'h0, link_bus.dout});
            end
        end
    end

    // Step counting, cycle completion and hang limit
    always @(posedge mclk_in) begin
        cyc++;
        if (cal_busy_out === 1'b1 && busy_p === 1'b0) begin
            ivl = cyc - rise_at;
            rise_at = cyc;
            rises++;
            since_done++;
        end
        busy_p = cal_busy_out;
        if (rst_b_in !== 1'b1 || link_bus.ce_b !== 1'b0 || link_bus.run !== 1'b1) seen_done = 0;
        if (cal_cycle_done_out === 1'b1) begin
            if (seen_done) chk("steps per cycle", 32'h7, since_done);
            seen_done = 1;
            since_done = 0;
        end
        if (cyc == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    initial begin
        rst_b_in = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = '0;
        avs_writedata = '0;
        repeat (6) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        pwrup_time();
        av(1'b0, REG_CTRL, 32'h0);
        chk("ctrl reset value", 32'h2, rd);
        av(1'b0, 4'h2, 32'h0);
        chk("unmapped read", 32'h0, rd);
        // External pulses: each starts one step
        r0 = rises;
        repeat (7) begin
            av(1'b1, REG_CMD, 32'h1);
            av(1'b0, REG_STATUS, 32'h0);
            chk("status busy", 32'h1, rd);
            repeat (25) @(posedge mclk_in);
        end
        chk("external steps", 32'h7, rises - r0);
        r0 = rises;
        repeat (200) @(posedge mclk_in);
        chk("no periodic steps", 32'h0, rises - r0);
        // Internal generator, then restart and run gating
        av(1'b1, REG_CTRL, 32'h3);
        av(1'b0, REG_CTRL, 32'h0);
        chk("ctrl readback", 32'h3, rd);
        repeat (9 * PER_CYC) @(posedge mclk_in);
        chk("internal interval", PER_CYC, ivl);
        // Restart just after a step ends, so no step is cut short
        while (cal_busy_out !== 1'b1) @(posedge mclk_in);
        while (cal_busy_out !== 1'b0) @(posedge mclk_in);
        av(1'b1, REG_CMD, 32'h2);
        pwrup_time();
        av(1'b1, REG_CTRL, 32'h0);
        repeat (100) @(posedge mclk_in);
        chk("held off by run", 32'h0, {31'h0, pwrup_done_out});
        av(1'b1, REG_CTRL, 32'h2);
        pwrup_time();
        tally_and_finish();
    end
endmodule
